// file: design/sar_host_end.sv
// Purpose: host end: starts conversions, reads words, buffers them for the user
// Assumes: link signals from the device are asynchronous to ref_clk_i
// Notes:   sclk is divided from ref_clk_i; a conversion starts only with buffer room
`timescale 1ns/1ps
module sar_fifo #(
  parameter int W     = 18,  // word width
  parameter int DEPTH = 16   // number of words
) (
  input  wire logic         clk_i,        // buffer clock
  input  wire logic         resetn_i,     // async reset, active low
  input  wire logic         in_valid_i,   // write request
  output logic              in_ready_o,   // room for a word
  input  wire logic [W-1:0] in_data_i,    // write data
  output logic              out_valid_o,  // word available
  input  wire logic         out_ready_i,  // reader takes the word
  output logic [W-1:0]      out_data_o    // oldest word
);
  localparam int AW = $clog2(DEPTH);

  // pointers carry one wrap bit so full and empty differ
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // storage
    logic [AW:0]             wr;   // write pointer
    logic [AW:0]             rd;   // read pointer
  } sar_fifo_t;

  sar_fifo_t q, n;   // registers and next value
  logic      full;   // no room
  logic      empty;  // nothing stored

  assign full  = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
  assign empty = (q.wr == q.rd);

  // pointer and storage update
  always_comb begin
    n = q;
    if (in_valid_i && !full) begin
      n.mem[q.wr[AW-1:0]] = in_data_i;
      n.wr                = q.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      n.rd = q.rd + 1'b1;
    end
  end

  // buffer registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = q.mem[q.rd[AW-1:0]];
endmodule

module sar_host_end (
  input  wire logic                     ref_clk_i,    // host clock
  input  wire logic                     resetn_i,     // async reset, active low
  sar_link_if.host                      link,         // serial link to device
  input  wire logic                     conv_req_i,   // pulse: run one conversion
  input  wire logic                     recal_req_i,  // pulse: recalibrate device
  output logic                          idle_o,       // sequencer idle
  output logic                          word_valid_o, // buffered word available
  input  wire logic                     word_ready_i, // user takes the word
  output logic [sar_pkg::OUT_W-1:0]     word_data_o   // oldest buffered word
);
  import sar_pkg::*;

  // all sequencer state
  typedef struct packed {
    sar_host_st_t     st;        // sequencer state
    logic [1:0]       busy_sync; // busy synchroniser
    logic [1:0]       sdo_sync;  // data synchroniser
    logic [7:0]       cnt;       // settle and half-period timer
    logic [BIT_W-1:0] bitcnt;    // bits taken
    logic [OUT_W-1:0] shreg;     // received word
    logic             sclk;      // serial clock wire
    logic             strobe;    // conversion start wire
    logic             recal;     // recalibration wire
    logic             conv_pend; // conversion asked for
    logic             recal_pend;// recalibration asked for
    logic             idle;      // idle flag
  } sar_host_t;

  sar_host_t q, n;       // registers and next value
  logic      fifo_room;  // buffer can take a word
  logic      push;       // word offered to buffer

  assign push = q.st == HS_PUSH;

  // sequencer next state
  always_comb begin
    logic busy_s;
    logic take_conv;
    logic take_recal;
    busy_s     = q.busy_sync[1];
    take_conv  = 1'b0;
    take_recal = 1'b0;
    n          = q;
    n.busy_sync = {q.busy_sync[0], link.busy};
    n.sdo_sync  = {q.sdo_sync[0], link.sdo};
    case (q.st)
      HS_IDLE: begin
        // wait out power-up calibration; recal goes first
        if (q.recal_pend && !busy_s) begin
          n.st       = HS_RECAL;
          n.recal    = 1'b1;
          take_recal = 1'b1;
        end else if (q.conv_pend && !busy_s && fifo_room) begin
          n.st      = HS_START;
          n.strobe  = 1'b1;
          take_conv = 1'b1;
        end
      end
      HS_RECAL: begin
        // hold the request until the device shows busy
        if (busy_s) begin
          n.st    = HS_IDLE;
          n.recal = 1'b0;
        end
      end
      HS_START: begin
        if (busy_s) begin
          n.st = HS_CONV;
        end
      end
      HS_CONV: begin
        // lower the strobe once conversion is over
        if (!busy_s) begin
          n.st     = HS_SETTLE;
          n.strobe = 1'b0;
          n.cnt    = '0;
        end
      end
      HS_SETTLE: begin
        // lets the device readout leave reset before sclk moves
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == 8'(SETTLE_CYCLES - 1)) begin
          n.st     = HS_SHIFT;
          n.cnt    = '0;
          n.bitcnt = '0;
        end
      end
      HS_SHIFT: begin
        // device drives on rising edge, host samples before falling edge
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == 8'(SCLK_HALF - 1)) begin
          n.cnt = '0;
          if (!q.sclk) begin
            n.sclk = 1'b1;
          end else begin
            n.sclk   = 1'b0;
            n.shreg  = {q.shreg[OUT_W-2:0], q.sdo_sync[1]};
            n.bitcnt = q.bitcnt + 1'b1;
            if (q.bitcnt == BIT_W'(OUT_W - 1)) begin
              n.st = HS_PUSH;
            end
          end
        end
      end
      HS_PUSH: begin
        // room was checked before the start, so this takes one cycle
        if (fifo_room) begin
          n.st = HS_IDLE;
        end
      end
      default: begin
        n.st = HS_IDLE;
      end
    endcase
    // a new request in the take cycle is kept: set wins
    n.conv_pend  = (q.conv_pend & ~take_conv) | conv_req_i;
    n.recal_pend = (q.recal_pend & ~take_recal) | recal_req_i;
    n.idle       = (n.st == HS_IDLE);
  end

  // sequencer registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q      <= '0;
      q.st   <= HS_IDLE;
      q.idle <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // receive buffer; back-pressure stops new conversions when full
  sar_fifo #(
    .W     (OUT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_room),
    .in_data_i   (q.shreg),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i),
    .out_data_o  (word_data_o)
  );

  assign link.sclk   = q.sclk;
  assign link.strobe = q.strobe;
  assign link.recal  = q.recal;
  assign idle_o      = q.idle;

endmodule

// file: design/sar_pkg.sv
// Purpose: shared constants and state encodings for both ends of the converter link
// Assumes: 250 MHz reference clock on each end, 18-bit serial output frame
// Notes:   counts derive from times in their own units
//
// Summary of operation
// - conversion starts on strobe rising edge
// - new result on serial output after strobe falls
// - strobe fall returns device to standby acquisition
// - host clocks result only during standby
// - conversion timed by internal clock, not serial clock
// - automatic self-calibration about 40 ms after power-up
// - after calibration enter low-current standby acquisition
// - recalibration command accepted any time, recalibrates
// - 14-bit results, every code reachable
// - accumulator sums up to 1024 consecutive results
// - accumulated results averaged, up to 18 bits out
// - three-wire link with optional busy indication
package sar_pkg;

  // data widths
  localparam int RES_W        = 14;               // converter resolution
  localparam int OUT_W        = 18;               // serial output word
  localparam int FRAC_W       = OUT_W - RES_W;    // extra bits gained by averaging
  localparam int ACC_LOG2_MAX = 10;               // up to 1024 results summed
  localparam int ACC_W        = RES_W + ACC_LOG2_MAX;
  localparam int LOG2_W       = 4;                // width of accumulation setting
  localparam int BIT_W        = 5;                // serial bit counter
  localparam int CNT_W        = 24;               // long timing counter

  // timing
  localparam int REF_PERIOD_NS = 4;               // 250 MHz reference
  localparam int PWRUP_CAL_MS  = 40;              // wait before auto calibration
  localparam int PWRUP_CYCLES  = PWRUP_CAL_MS * 1000000 / REF_PERIOD_NS;
  localparam int CAL_CYCLES    = 512;             // length of one self-calibration
  localparam int SCLK_HALF     = 4;               // host sclk half period in ref cycles
  localparam int SETTLE_CYCLES = 8;               // strobe low before first sclk edge
  localparam int FIFO_DEPTH    = 16;              // host receive buffer

  // device core states
  typedef enum logic [4:0] {
    DS_PWRUP = 5'h01,                             // waiting after power-up
    DS_CAL   = 5'h02,                             // self-calibration running
    DS_STBY  = 5'h04,                             // standby acquisition
    DS_CONV  = 5'h08,                             // successive approximation
    DS_DONE  = 5'h10                              // done, waiting for strobe low
  } sar_dev_st_t;

  // host sequencer states
  typedef enum logic [6:0] {
    HS_IDLE   = 7'h01,
    HS_RECAL  = 7'h02,
    HS_START  = 7'h04,
    HS_CONV   = 7'h08,
    HS_SETTLE = 7'h10,
    HS_SHIFT  = 7'h20,
    HS_PUSH   = 7'h40
  } sar_host_st_t;

endpackage

// file: design/sar_link_if.sv
// Purpose: three-wire serial link plus busy and recalibration wires
// Assumes: host makes sclk and strobe, device answers on sdo and busy
// Notes:   all wires single driver, no tristate
`timescale 1ns/1ps
interface sar_link_if;
  logic strobe;   // conversion start strobe, host to device
  logic sclk;     // serial clock, host to device, idle low
  logic sdo;      // serial data, device to host
  logic busy;     // power-up wait, calibration or conversion in progress
  logic recal;    // recalibration request level, host to device

  modport dev  (input strobe, input sclk, input recal, output sdo, output busy);
  modport host (output strobe, output sclk, output recal, input sdo, input busy);
endinterface

// file: design/sar_dev_end.sv
// Purpose: converter end: calibration, conversion, accumulation and serial readout
// Assumes: sample_i is the held input already in ref_clk_i domain
// Notes:   readout logic runs on the link's sclk, cleared while strobe is high
`timescale 1ns/1ps
module sar_dev_end #(
  parameter int PWRUP_CYC = sar_pkg::PWRUP_CYCLES  // power-up wait, shorten in sim
) (
  input  wire logic                       ref_clk_i,    // internal conversion clock
  input  wire logic                       resetn_i,     // async reset, active low
  sar_link_if.dev                         link,         // serial link to host
  input  wire logic [sar_pkg::RES_W-1:0]  sample_i,     // held input, digitised
  input  wire logic [sar_pkg::LOG2_W-1:0] accum_log2_i, // log2 of results per word
  output logic                            ready_o,      // calibrated, not converting
  output logic [sar_pkg::OUT_W-1:0]       result_o      // latest output word
);
  import sar_pkg::*;

  // core state in the internal clock domain
  typedef struct packed {
    sar_dev_st_t          st;        // core state
    logic [2:0]           cnv_sync;  // strobe sync [0],[1] and previous [2]
    logic [2:0]           rcl_sync;  // recal sync [0],[1] and previous [2]
    logic                 rcl_pend;  // recal seen outside standby, kept until taken
    logic [CNT_W-1:0]     cnt;       // power-up and calibration timer
    logic [RES_W-1:0]     held;      // sampled input
    logic [RES_W-1:0]     sar;       // approximation register
    logic [RES_W-1:0]     tbit;      // bit under trial
    logic [ACC_W-1:0]     acc;       // running sum
    logic [ACC_LOG2_MAX:0] nacc;     // results in the sum
    logic [OUT_W-1:0]     word;      // word offered on the link
    logic                 busy;      // busy wire
    logic                 ready;     // idle and calibrated
  } sar_dev_core_t;

  // readout state in the sclk domain
  typedef struct packed {
    logic [BIT_W-1:0] bitcnt;        // bits already driven
    logic             sdo;           // data wire
  } sar_dev_lnk_t;

  sar_dev_core_t q, n;               // core registers and next value
  sar_dev_lnk_t  lq, ln;             // readout registers and next value
  logic          lnk_rst_n;          // readout reset, also held by strobe

  // core next-state logic
  always_comb begin
    logic [RES_W-1:0]        trial;
    logic [RES_W-1:0]        fin;
    logic [ACC_W-1:0]        acc_new;
    logic [ACC_W+FRAC_W-1:0] wide;
    logic [LOG2_W-1:0]       lg;
    logic [ACC_LOG2_MAX:0]   target;
    logic                    cnv_rise;
    logic                    cnv_high;
    logic                    rcl_rise;
    trial    = q.sar | q.tbit;
    fin      = (trial <= q.held) ? trial : q.sar;
    acc_new  = q.acc + ACC_W'(fin);
    lg       = (accum_log2_i > LOG2_W'(ACC_LOG2_MAX)) ? LOG2_W'(ACC_LOG2_MAX) : accum_log2_i;
    target   = (ACC_LOG2_MAX+1)'(1) << lg;
    wide     = {acc_new, FRAC_W'(0)} >> lg;
    n        = q;
    // only the second and third flops of each synchroniser are looked at
    n.cnv_sync = {q.cnv_sync[1], q.cnv_sync[0], link.strobe};
    n.rcl_sync = {q.rcl_sync[1], q.rcl_sync[0], link.recal};
    cnv_rise = q.cnv_sync[1] & ~q.cnv_sync[2];
    cnv_high = q.cnv_sync[1];
    rcl_rise = q.rcl_sync[1] & ~q.rcl_sync[2];
    // a request during conversion waits, it is never dropped
    if (rcl_rise) begin
      n.rcl_pend = 1'b1;
    end
    case (q.st)
      DS_PWRUP: begin
        // wait for supplies to settle, then calibrate
        n.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(PWRUP_CYC - 1)) begin
          n.st  = DS_CAL;
          n.cnt = '0;
        end
      end
      DS_CAL: begin
        // offset, gain and linearity trim run on the internal clock
        // a request arriving mid-calibration stays pending: set wins
        n.cnt      = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(CAL_CYCLES - 1)) begin
          n.st    = DS_STBY;
          n.busy  = 1'b0;
          n.ready = 1'b1;
          n.acc   = '0;
          n.nacc  = '0;
        end
      end
      DS_STBY: begin
        // recalibration has priority over a new conversion
        if (q.rcl_pend || rcl_rise) begin
          n.st       = DS_CAL;
          n.cnt      = '0;
          n.busy     = 1'b1;
          n.ready    = 1'b0;
          n.rcl_pend = 1'b0;
        end else if (cnv_rise) begin
          n.st    = DS_CONV;
          n.held  = sample_i;
          n.sar   = '0;
          n.tbit  = {1'b1, (RES_W-1)'(0)};
          n.busy  = 1'b1;
          n.ready = 1'b0;
        end
      end
      DS_CONV: begin
        // one bit per internal clock, sclk plays no part
        n.sar  = fin;
        n.tbit = q.tbit >> 1;
        if (q.tbit[0]) begin
          n.st   = DS_DONE;
          n.busy = 1'b0;
          n.nacc = q.nacc + 1'b1;
          n.acc  = acc_new;
          if (q.nacc + 1'b1 == target) begin
            n.word = wide[OUT_W-1:0];
            n.acc  = '0;
            n.nacc = '0;
          end
        end
      end
      DS_DONE: begin
        // back to acquisition once the host lowers the strobe
        if (!cnv_high) begin
          n.st    = DS_STBY;
          n.ready = 1'b1;
        end
      end
      default: begin
        n.st = DS_PWRUP;
      end
    endcase
  end

  // core registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q      <= '0;
      q.st   <= DS_PWRUP;
      q.busy <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // readout clears while the strobe is high, so every frame starts at the msb
  assign lnk_rst_n = resetn_i & ~link.strobe;

  // readout next state: word is quasi-static, it only changes while strobe is high
  always_comb begin
    logic [BIT_W-1:0] idx;
    idx = BIT_W'(OUT_W - 1) - lq.bitcnt;
    ln  = lq;
    if (lq.bitcnt < BIT_W'(OUT_W)) begin
      ln.sdo    = q.word[idx];
      ln.bitcnt = lq.bitcnt + 1'b1;
    end
  end

  // readout registers on the link clock, a bit per rising edge
  always_ff @(posedge link.sclk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      lq <= '0;
    end else begin
      lq <= ln;
    end
  end

  assign link.sdo  = lq.sdo;
  assign link.busy = q.busy;
  assign ready_o   = q.ready;
  assign result_o  = q.word;

endmodule

// file: bench/sar_link_checker.sv
// Purpose: concurrent checks on the wires between the two converter ends
// Assumes: every wire is sampled on the host reference clock
// Notes:   frame length counted as sclk rises between two strobes
`timescale 1ns/1ps
module sar_link_checker (
  input wire logic ref_clk_i, // host clock, samples all wires
  input wire logic resetn_i,  // async reset, active low
  input wire logic strobe,    // conversion start strobe
  input wire logic sclk,      // serial clock
  input wire logic sdo,       // serial data
  input wire logic busy,      // device busy
  input wire logic recal      // recalibration request
);
  typedef struct packed {
    logic       sclk; // sclk one sample back
    logic [5:0] cnt;  // sclk rises in this frame
  } sar_chk_st_t;
  sar_chk_st_t st_q; // helper state
  sar_chk_st_t st_d; // next helper state

  // count rises, restart while strobe is high
  always_comb begin
    st_d = st_q;
    st_d.sclk = sclk;
    if (strobe) begin
      st_d.cnt = 6'h00;
    end else if (sclk && !st_q.sclk && st_q.cnt != 6'h3F) begin
      st_d.cnt = st_q.cnt + 6'h01; // saturates so an overrun cannot wrap back to 18
    end
  end

  // helper register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // conversion length: busy about 14 device cycles
  sequence s_conv_busy;
    busy[*8] ##1 busy[*4];
  endsequence
  sequence s_to_done;
    ##[1:40] $fell(busy);
  endsequence

  property p_pwrup_busy; $rose(resetn_i) |-> busy[*8]; endproperty
  property p_strobe_busy; $rose(strobe) && !busy |-> ##[1:10] busy; endproperty
  property p_conv_len; $rose(busy) && strobe |-> s_conv_busy ##[1:6] !busy; endproperty
  property p_strobe_hold; $rose(strobe) |-> strobe throughout s_to_done; endproperty
  property p_strobe_drop; $fell(busy) && strobe |-> ##[1:8] !strobe; endproperty
  property p_sdo_clear; strobe && $past(strobe) |-> !sdo; endproperty
  property p_no_sclk_busy; busy |-> !sclk; endproperty
  property p_settle; $fell(strobe) |-> !sclk[*7]; endproperty
  property p_sclk_half; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
  property p_frame_len; $rose(strobe) |-> st_q.cnt == 6'h00 || st_q.cnt == 6'h12; endproperty
  property p_recal_busy; $rose(recal) |-> recal throughout (##[1:16] busy); endproperty
  property p_recal_len; $fell(recal) && !strobe |-> busy[*8]; endproperty

  a_pwrup_busy: assert property (p_pwrup_busy)
    else $error("busy not held after reset release");
  a_strobe_busy: assert property (p_strobe_busy)
    else $error("strobe rise did not start a conversion");
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  a_strobe_hold: assert property (p_strobe_hold)
    else $error("strobe dropped before conversion end");
  a_strobe_drop: assert property (p_strobe_drop)
    else $error("strobe not lowered after conversion");
  a_sdo_clear: assert property (p_sdo_clear)
    else $error("serial data not cleared under strobe");
  a_no_sclk_busy: assert property (p_no_sclk_busy)
    else $error("serial clock toggled while busy");
  a_settle: assert property (p_settle)
    else $error("serial clock too soon after strobe fall");
  a_sclk_half: assert property (p_sclk_half)
    else $error("serial clock half period wrong");
  a_frame_len: assert property (p_frame_len)
    else $error("frame bit count wrong");
  a_recal_busy: assert property (p_recal_busy)
    else $error("recalibration request not answered");
  a_recal_len: assert property (p_recal_len)
    else $error("calibration ended too soon");
endmodule

// file: bench/tb_sar_adc_conversion_readout.sv
// Purpose: drives both converter ends through conversions, buffering and recalibration
// Assumes: shortened power-up wait, device on its own phase-shifted clock
// Notes:   link wires are also watched by the checker beside the interface
`timescale 1ns/1ps
module tb_sar_adc_conversion_readout;
  import sar_pkg::*;
  localparam int PW = 100;             // shortened power-up wait
  logic              ref_clk_i;        // host clock
  logic              dev_clk;          // device clock, other phase
  logic              resetn_i;         // shared reset, active low
  logic              conv_req;         // conversion request pulse
  logic              recal_req;        // recalibration request pulse
  logic              word_ready;       // user pops a word
  logic [RES_W-1:0]  sample;           // held input value
  logic [LOG2_W-1:0] accum_log2;       // averaging setting
  logic              ready, idle, word_valid;
  logic [OUT_W-1:0]  word_data, result, wire_word, exp_w;
  logic [19:0]       sum;              // wide enough for four codes shifted
  int                fail_count, num_checks, i;
  logic [RES_W-1:0]  codes [4] = '{14'h0000, 14'h3FFF, 14'h2AAA, 14'h1555};

  sar_link_if sar_link_if_i ();
  sar_dev_end #(.PWRUP_CYC(PW)) sar_dev_end_i (.ref_clk_i(dev_clk), .resetn_i(resetn_i),
    .link(sar_link_if_i), .sample_i(sample), .accum_log2_i(accum_log2), .ready_o(ready),
    .result_o(result));
  sar_host_end sar_host_end_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(sar_link_if_i),
    .conv_req_i(conv_req), .recal_req_i(recal_req), .idle_o(idle), .word_valid_o(word_valid),
    .word_ready_i(word_ready), .word_data_o(word_data));
  sar_link_checker sar_link_checker_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .strobe(sar_link_if_i.strobe), .sclk(sar_link_if_i.sclk), .sdo(sar_link_if_i.sdo),
    .busy(sar_link_if_i.busy), .recal(sar_link_if_i.recal));

  // clocks: device clock shifted so the two never share an edge
  initial ref_clk_i = 1'b0;
  always #2 ref_clk_i = ~ref_clk_i;
  initial begin
    dev_clk = 1'b0;
    #1.3;
    forever #2 dev_clk = ~dev_clk;
  end

  // shift in what the wire carries, sampled where sdo is stable
  always @(negedge sar_link_if_i.sclk) wire_word <= {wire_word[OUT_W-2:0], sar_link_if_i.sdo};

  task automatic test_done();
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [OUT_W-1:0] got, input logic [OUT_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk({{(OUT_W-1){1'b0}}, got}, {{(OUT_W-1){1'b0}}, exp});
  endtask

  function automatic logic cond(input int w);
    case (w)
      0: return idle;
      1: return ready;
      2: return word_valid;
      default: return sar_link_if_i.busy;
    endcase
  endfunction

  // bounded wait, sampled at the falling edge where flops have settled
  task automatic wait_on(input int w, input logic lvl, input int lim);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (cond(w) !== lvl && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (cond(w) !== lvl) begin
      fail_count++;
      $display("BAD t=%0t wait=%h lvl=%h", $time, w, lvl);
      test_done();
    end
  endtask

  task automatic pulse(input logic [RES_W-1:0] s);
    @(posedge ref_clk_i);
    sample <= s;
    conv_req <= 1'b1;
    @(posedge ref_clk_i);
    conv_req <= 1'b0;
  endtask

  task automatic conv(input logic [RES_W-1:0] s);
    pulse(s);
    wait_on(0, 1'b0, 20);
    wait_on(0, 1'b1, 600);
  endtask

  task automatic pop(input logic [OUT_W-1:0] exp, input logic check_it);
    wait_on(2, 1'b1, 600);
    if (check_it) begin
      chk(word_data, exp);
    end
    @(posedge ref_clk_i);
    word_ready <= 1'b1;
    @(posedge ref_clk_i);
    word_ready <= 1'b0;
  endtask

  // main sequence
  initial begin
    resetn_i = 1'b0;
    conv_req = 1'b0;
    recal_req = 1'b0;
    word_ready = 1'b0;
    sample = '0;
    accum_log2 = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(negedge ref_clk_i);
    chk_flag(sar_link_if_i.busy, 1'b1);
    chk_flag(ready, 1'b0);
    wait_on(1, 1'b1, PW + 1000);
    chk_flag(sar_link_if_i.busy, 1'b0);
    // boundary and alternating-bit codes, one word each, checked on the wire too
    for (i = 0; i < 4; i++) begin
      conv(codes[i]);
      chk(result, {codes[i], 4'h0});
      pop({codes[i], 4'h0}, 1'b1);
      chk(wire_word, {codes[i], 4'h0});
    end
    // fill the buffer, then one more request must wait for room
    for (i = 0; i < 16; i++) begin
      conv(14'(i * 1000 + 7));
    end
    pulse(14'h2F0F);
    repeat (400) @(posedge ref_clk_i);
    chk(result, {14'(15 * 1000 + 7), 4'h0});
    for (i = 0; i < 16; i++) begin
      pop({14'(i * 1000 + 7), 4'h0}, 1'b1);
    end
    pop({14'h2F0F, 4'h0}, 1'b1);
    // recalibrate, then average four results
    @(posedge ref_clk_i);
    accum_log2 <= 4'h2;
    recal_req <= 1'b1;
    @(posedge ref_clk_i);
    recal_req <= 1'b0;
    wait_on(3, 1'b1, 40);
    chk_flag(ready, 1'b0);
    wait_on(1, 1'b1, 1000);
    sum = '0;
    for (i = 0; i < 4; i++) begin
      conv(codes[1] - 14'(i / 3 * 2));
      sum = sum + 20'(codes[1] - 14'(i / 3 * 2));
    end
    exp_w = OUT_W'((sum << 4) >> 2);
    chk(result, exp_w);
    // intermediate frames still carry the last finished word
    for (i = 0; i < 4; i++) begin
      pop((i == 3) ? exp_w : {14'h2F0F, 4'h0}, 1'b1);
    end
    test_done();
  end
endmodule
